/* File: design/atc_pkg.sv */
// Package with register map, field positions and state type of the auxiliary timer
package atc_pkg;

  localparam int ATC_DATA_W = 32;
  localparam int ATC_IDX_W = 10;
  localparam int ATC_ADDR_LSB = 2;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [ATC_IDX_W-1:0] ATC_IDX_CTRL = 10'h0c8;
  localparam logic [ATC_IDX_W-1:0] ATC_IDX_RLD_LO = 10'h0ca;
  localparam logic [ATC_IDX_W-1:0] ATC_IDX_RLD_HI = 10'h0cb;
  localparam logic [ATC_IDX_W-1:0] ATC_IDX_CNT_LO = 10'h0cc;
  localparam logic [ATC_IDX_W-1:0] ATC_IDX_CNT_HI = 10'h0cd;
  localparam logic [ATC_IDX_W-1:0] ATC_IDX_IRQ_STAT = 10'h0ce;
  localparam logic [ATC_IDX_W-1:0] ATC_IDX_IRQ_MASK = 10'h0cf;

  // Control/status register fields
  localparam int ATC_B_OVF = 7;
  localparam int ATC_B_EDGE = 6;
  localparam int ATC_B_RXSEL = 5;
  localparam int ATC_B_TXSEL = 4;
  localparam int ATC_B_TRIGEN = 3;
  localparam int ATC_B_RUN = 2;
  localparam int ATC_B_CTSEL = 1;
  localparam int ATC_B_CPRL = 0;

  // Interrupt status and mask fields
  localparam int ATC_IRQ_W = 2;
  localparam int ATC_IRQ_OVF = 0;
  localparam int ATC_IRQ_EDGE = 1;

  localparam logic [7:0] ATC_BYTE_RST = 8'h00;
  localparam logic [15:0] ATC_CNT_MAX = 16'hffff;
  localparam logic [15:0] ATC_CNT_ONE = 16'h0001;

  // Serial port modes in which the baud source selection applies
  localparam logic [1:0] ATC_UART_MODE1 = 2'h1;
  localparam logic [1:0] ATC_UART_MODE3 = 2'h3;

  localparam logic ATC_HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] reload;
    logic [15:0] count;
    logic prescale;
    logic [ATC_IRQ_W-1:0] irqStat;
    logic [ATC_IRQ_W-1:0] irqMask;
    logic aWrite;
    logic [ATC_IDX_W-1:0] aIdx;
    logic [ATC_DATA_W-1:0] hrdata;
    logic hready;
    logic hresp;
    logic irq;
    logic rxTick;
    logic txTick;
  } atc_state_t;

  localparam atc_state_t ATC_STATE_RST = '{hready: 1'b1, hresp: ATC_HRESP_OKAY, default: '0};

  typedef struct packed {
    logic trigPrev;
    logic countPrev;
  } atc_edge_state_t;

  localparam atc_edge_state_t ATC_EDGE_RST = '{default: '0};

endpackage

/* File: design/atc_edge_if.sv */
// Interface carrying pin falling-edge events into the timer core
`timescale 1ns/1ps
interface atc_edge_if;
  logic trigFall;
  logic countFall;
  modport src (output trigFall, output countFall);
  modport dst (input trigFall, input countFall);
endinterface

/* File: design/atc_edge_detect.sv */
// Falling-edge detector for the trigger and count input pins
`timescale 1ns/1ps
module atc_edge_detect
  import atc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic triggerPin,
  input wire logic countInputPin,
  atc_edge_if.src edges
);
  import atc_pkg::*;

  atc_edge_state_t state_q;
  atc_edge_state_t state_d;

  // Previous levels reset low so a pin held low at reset gives no false edge
  always_comb begin
    state_d = state_q;
    state_d.trigPrev = triggerPin;
    state_d.countPrev = countInputPin;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ATC_EDGE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  assign edges.trigFall = state_q.trigPrev & ~triggerPin;
  assign edges.countFall = state_q.countPrev & ~countInputPin;

endmodule

/* File: design/atc_aux_timer.sv */
// Sixteen-bit auxiliary timer with capture, auto-reload and baud output, AHB-Lite slave
//
// Overview of operation
// - Overflow flag set on overflow unless a baud select is 1; only software clears.
// - Edge flag set when trigger falling edge causes capture or reload; software clears.
// - Receive baud select picks other timer (0) or this timer (1) overflow.
// - Transmit baud select picks other timer (0) or this timer (1) overflow.
// - Trigger pin ignored unless enabled and both baud selects are 0.
// - All flag and control bits read 0 after reset.
// - Counter/timer select: 0 counts every two clocks, 1 counts count-pin falls.
// - Reload on overflow or trigger, or capture on trigger; baud forces reload.
// - Reload/capture value is two read/write bytes, reset to 00h.
// - Running count is two read/write bytes, reset to 00h.
`timescale 1ns/1ps
module atc_aux_timer
  import atc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [ATC_DATA_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [ATC_DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic [ATC_DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic triggerPin,
  input wire logic countInputPin,
  input wire logic [1:0] serialMode,
  input wire logic otherTimerOvf,
  output logic rxBaudTick,
  output logic txBaudTick,
  output logic irq
);
  import atc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Read decode

  function automatic logic [ATC_DATA_W-1:0] atcReadReg(
    input logic [ATC_IDX_W-1:0] idx,
    input atc_state_t s
  );
    logic [ATC_DATA_W-1:0] r;
    r = '0;
    unique case (idx)
      ATC_IDX_CTRL: r[7:0] = s.ctrl;
      ATC_IDX_RLD_LO: r[7:0] = s.reload[7:0];
      ATC_IDX_RLD_HI: r[7:0] = s.reload[15:8];
      ATC_IDX_CNT_LO: r[7:0] = s.count[7:0];
      ATC_IDX_CNT_HI: r[7:0] = s.count[15:8];
      ATC_IDX_IRQ_STAT: r[ATC_IRQ_W-1:0] = s.irqStat;
      ATC_IDX_IRQ_MASK: r[ATC_IRQ_W-1:0] = s.irqMask;
      default: r = '0;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin edges

  atc_edge_if edges ();

  atc_edge_detect u_edge (
    .mclk(mclk),
    .rst(rst),
    .triggerPin(triggerPin),
    .countInputPin(countInputPin),
    .edges(edges)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  atc_state_t state_q;
  atc_state_t state_d;
  logic baudSel;
  logic runOn;
  logic tick;
  logic incEv;
  logic ovfEv;
  logic trigEv;
  logic ctrlWr;
  logic rldLoWr;
  logic rldHiWr;
  logic cntLoWr;
  logic cntHiWr;
  logic statWr;
  logic maskWr;
  logic addrTaken;
  logic modeBaud;
  logic [7:0] wByte;
  logic [7:0] setBits;
  logic [ATC_IRQ_W-1:0] irqEv;

  always_comb begin
    state_d = state_q;
    wByte = hwdata[7:0];
    baudSel = state_q.ctrl[ATC_B_RXSEL] | state_q.ctrl[ATC_B_TXSEL];
    runOn = state_q.ctrl[ATC_B_RUN];
    ctrlWr = state_q.aWrite && (state_q.aIdx == ATC_IDX_CTRL);
    rldLoWr = state_q.aWrite && (state_q.aIdx == ATC_IDX_RLD_LO);
    rldHiWr = state_q.aWrite && (state_q.aIdx == ATC_IDX_RLD_HI);
    cntLoWr = state_q.aWrite && (state_q.aIdx == ATC_IDX_CNT_LO);
    cntHiWr = state_q.aWrite && (state_q.aIdx == ATC_IDX_CNT_HI);
    statWr = state_q.aWrite && (state_q.aIdx == ATC_IDX_IRQ_STAT);
    maskWr = state_q.aWrite && (state_q.aIdx == ATC_IDX_IRQ_MASK);

    // Prescaler toggles while running so timer mode counts on every second clock
    state_d.prescale = runOn & ~state_q.prescale;
    tick = state_q.ctrl[ATC_B_CTSEL] ? edges.countFall : state_q.prescale;
    incEv = runOn & tick;
    ovfEv = incEv && (state_q.count == ATC_CNT_MAX);
    trigEv = state_q.ctrl[ATC_B_TRIGEN] & edges.trigFall & ~baudSel;

    if (incEv) begin
      state_d.count = state_q.count + ATC_CNT_ONE;
    end
    if (ovfEv && (baudSel || !state_q.ctrl[ATC_B_CPRL])) begin
      state_d.count = state_q.reload;
    end
    if (trigEv) begin
      if (state_q.ctrl[ATC_B_CPRL]) begin
        state_d.reload = state_q.count;
      end else begin
        state_d.count = state_q.reload;
      end
    end

    // Hardware sets are ORed after the software write so a set is never lost
    setBits = '0;
    setBits[ATC_B_OVF] = ovfEv & ~baudSel;
    setBits[ATC_B_EDGE] = trigEv;
    state_d.ctrl = (ctrlWr ? wByte : state_q.ctrl) | setBits;

    // Software byte writes win over counting in the same cycle
    if (rldLoWr) begin
      state_d.reload[7:0] = wByte;
    end
    if (rldHiWr) begin
      state_d.reload[15:8] = wByte;
    end
    if (cntLoWr) begin
      state_d.count[7:0] = wByte;
    end
    if (cntHiWr) begin
      state_d.count[15:8] = wByte;
    end

    irqEv = '0;
    irqEv[ATC_IRQ_OVF] = setBits[ATC_B_OVF];
    irqEv[ATC_IRQ_EDGE] = setBits[ATC_B_EDGE];
    state_d.irqStat = (state_q.irqStat & ~(statWr ? hwdata[ATC_IRQ_W-1:0] : '0)) | irqEv;
    if (maskWr) begin
      state_d.irqMask = hwdata[ATC_IRQ_W-1:0];
    end

    // Zero-wait slave; reads return the value as it stands after this edge
    addrTaken = hsel & hready & htrans[1];
    state_d.aWrite = addrTaken & hwrite;
    state_d.aIdx = haddr[ATC_ADDR_LSB+ATC_IDX_W-1:ATC_ADDR_LSB];
    state_d.hready = 1'b1;
    state_d.hresp = ATC_HRESP_OKAY;
    state_d.hrdata = '0;
    if (addrTaken && !hwrite) begin
      state_d.hrdata = atcReadReg(state_d.aIdx, state_d);
    end
    state_d.irq = |(state_d.irqStat & state_d.irqMask);

    modeBaud = (serialMode == ATC_UART_MODE1) || (serialMode == ATC_UART_MODE3);
    state_d.rxTick = modeBaud & (state_q.ctrl[ATC_B_RXSEL] ? ovfEv : otherTimerOvf);
    state_d.txTick = modeBaud & (state_q.ctrl[ATC_B_TXSEL] ? ovfEv : otherTimerOvf);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ATC_STATE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  assign hrdata = state_q.hrdata;
  assign hreadyout = state_q.hready;
  assign hresp = state_q.hresp;
  assign rxBaudTick = state_q.rxTick;
  assign txBaudTick = state_q.txTick;
  assign irq = state_q.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_ovf_set;
    @(posedge mclk) disable iff (rst)
    (ovfEv && !baudSel) |=> state_q.ctrl[ATC_B_OVF];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

  property p_ovf_baud_hold;
    @(posedge mclk) disable iff (rst)
    (baudSel && !ctrlWr) |=> $stable(state_q.ctrl[ATC_B_OVF]);
  endproperty
  a_ovf_baud_hold: assert property (p_ovf_baud_hold) else $error("overflow flag moved");

  property p_edge_set;
    @(posedge mclk) disable iff (rst)
    trigEv |=> state_q.ctrl[ATC_B_EDGE] ##1 (state_q.ctrl[ATC_B_EDGE] || $past(ctrlWr));
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge flag not set");

  property p_trig_ignore;
    @(posedge mclk) disable iff (rst)
    (!state_q.ctrl[ATC_B_TRIGEN] && !ctrlWr) |=> $stable(state_q.ctrl[ATC_B_EDGE]);
  endproperty
  a_trig_ignore: assert property (p_trig_ignore) else $error("trigger not ignored");

  property p_capture;
    @(posedge mclk) disable iff (rst)
    (trigEv && state_q.ctrl[ATC_B_CPRL] && !rldLoWr && !rldHiWr)
      |=> state_q.reload == $past(state_q.count);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_reload_ovf;
    @(posedge mclk) disable iff (rst)
    (ovfEv && (baudSel || !state_q.ctrl[ATC_B_CPRL]) && !cntLoWr && !cntHiWr && !trigEv)
      |=> state_q.count == $past(state_q.reload);
  endproperty
  a_reload_ovf: assert property (p_reload_ovf) else $error("no reload on overflow");

  property p_run_hold;
    @(posedge mclk) disable iff (rst)
    (!runOn && !trigEv && !cntLoWr && !cntHiWr) |=> $stable(state_q.count);
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("count moved while stopped");

  property p_timer_rate;
    @(posedge mclk) disable iff (rst)
    (incEv && !state_q.ctrl[ATC_B_CTSEL] && !ctrlWr) |=> !incEv;
  endproperty
  a_timer_rate: assert property (p_timer_rate) else $error("timer counted too fast");

  property p_rx_baud;
    @(posedge mclk) disable iff (rst)
    (modeBaud && state_q.ctrl[ATC_B_RXSEL]) |=> rxBaudTick == $past(ovfEv);
  endproperty
  a_rx_baud: assert property (p_rx_baud) else $error("receive baud tick wrong");

  property p_tx_baud;
    @(posedge mclk) disable iff (rst)
    (modeBaud && !state_q.ctrl[ATC_B_TXSEL]) |=> txBaudTick == $past(otherTimerOvf);
  endproperty
  a_tx_baud: assert property (p_tx_baud) else $error("transmit baud tick wrong");

  property p_wrap;
    @(posedge mclk) disable iff (rst)
    (ovfEv && state_q.ctrl[ATC_B_CPRL] && !baudSel && !trigEv && !cntLoWr && !cntHiWr)
      |=> state_q.count == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap to zero");

  property p_ovf_no_hw_clear;
    @(posedge mclk) disable iff (rst)
    (state_q.ctrl[ATC_B_OVF] && !ctrlWr) |=> state_q.ctrl[ATC_B_OVF];
  endproperty
  a_ovf_no_hw_clear: assert property (p_ovf_no_hw_clear) else $error("overflow flag lost");

  property p_edge_no_hw_clear;
    @(posedge mclk) disable iff (rst)
    (state_q.ctrl[ATC_B_EDGE] && !ctrlWr) |=> state_q.ctrl[ATC_B_EDGE];
  endproperty
  a_edge_no_hw_clear: assert property (p_edge_no_hw_clear) else $error("edge flag lost");

  property p_trig_reload;
    @(posedge mclk) disable iff (rst)
    (trigEv && !state_q.ctrl[ATC_B_CPRL] && !cntLoWr && !cntHiWr)
      |=> state_q.count == $past(state_q.reload);
  endproperty
  a_trig_reload: assert property (p_trig_reload) else $error("no reload on trigger");

  property p_rx_other;
    @(posedge mclk) disable iff (rst)
    (modeBaud && !state_q.ctrl[ATC_B_RXSEL]) |=> rxBaudTick == $past(otherTimerOvf);
  endproperty
  a_rx_other: assert property (p_rx_other) else $error("receive tick not from other timer");

  property p_tx_own;
    @(posedge mclk) disable iff (rst)
    (modeBaud && state_q.ctrl[ATC_B_TXSEL]) |=> txBaudTick == $past(ovfEv);
  endproperty
  a_tx_own: assert property (p_tx_own) else $error("transmit tick not from own overflow");

  property p_no_baud_mode;
    @(posedge mclk) disable iff (rst)
    !modeBaud |=> (!rxBaudTick && !txBaudTick);
  endproperty
  a_no_baud_mode: assert property (p_no_baud_mode) else $error("baud tick outside modes");

  property p_count_step;
    @(posedge mclk) disable iff (rst)
    (incEv && !ovfEv && !trigEv && !cntLoWr && !cntHiWr)
      |=> state_q.count == $past(state_q.count) + ATC_CNT_ONE;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step by one");

endmodule

/* File: bench/atc_pin_model.sv */
// Model of the pins and serial-port side that surround the auxiliary timer
`timescale 1ns/1ps
module atc_pin_model (
  input wire logic mclk,
  input wire logic rxBaudTick,
  input wire logic txBaudTick,
  output logic triggerPin,
  output logic countInputPin,
  output logic [1:0] serialMode,
  output logic otherTimerOvf
);
  logic [1:0] pins = 2'b00;
  logic [1:0] modeQ = 2'h0;
  logic otherQ = 1'b0;
  int rxTicks = 0;
  int txTicks = 0;
  assign triggerPin = pins[0];
  assign countInputPin = pins[1];
  assign serialMode = modeQ;
  assign otherTimerOvf = otherQ;
  ////////////////////////////////////////////////////////////////////////////////////////
  // Ticks are one-cycle pulses, so every high cycle is one baud clock
  always @(posedge mclk) begin
    if (rxBaudTick === 1'b1) rxTicks++;
    if (txBaudTick === 1'b1) txTicks++;
  end
  // Pins rest low; a pulse gives exactly one falling edge
  task automatic pulse(input int b);
    @(posedge mclk) pins[b] <= 1'b1;
    repeat (2) @(posedge mclk);
    pins[b] <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic other_pulse();
    @(posedge mclk) otherQ <= 1'b1;
    @(posedge mclk) otherQ <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic set_mode(input logic [1:0] m);
    @(posedge mclk) modeQ <= m;
  endtask
endmodule

/* File: bench/tb_aux_timer_capture_reload_baud.sv */
// Self-checking testbench of the auxiliary timer over AHB-Lite
`timescale 1ns/1ps
module tb_aux_timer_capture_reload_baud;
  import atc_pkg::*;
  logic mclk, rst, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, serialMode;
  logic [2:0] hsize;
  logic triggerPin, countInputPin, otherTimerOvf, rxBaudTick, txBaudTick;
  int failures = 0;
  int tests_run = 0;
  int r0, t0;
  atc_aux_timer i_atc_aux_timer (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .triggerPin(triggerPin),
    .countInputPin(countInputPin), .serialMode(serialMode), .otherTimerOvf(otherTimerOvf),
    .rxBaudTick(rxBaudTick), .txBaudTick(txBaudTick), .irq(irq));
  atc_pin_model i_atc_pin_model (.mclk(mclk), .rxBaudTick(rxBaudTick),
    .txBaudTick(txBaudTick), .triggerPin(triggerPin), .countInputPin(countInputPin),
    .serialMode(serialMode), .otherTimerOvf(otherTimerOvf));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait so a stuck slave ends the run instead of hanging it
  task automatic wait_ready();
    int n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      failures++;
      close_out();
    end
  endtask
  task automatic bus(input logic wr, input logic [ATC_IDX_W-1:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic wr(input logic [ATC_IDX_W-1:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task automatic rdc(input logic [ATC_IDX_W-1:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, idx, 32'h0000_0000, x);
    check(x, exp);
    check({31'h0, hresp}, 32'h0000_0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc(ATC_IDX_CTRL, 32'h0000_0000);
    rdc(ATC_IDX_RLD_LO, 32'h0000_0000);
    rdc(ATC_IDX_RLD_HI, 32'h0000_0000);
    rdc(ATC_IDX_CNT_LO, 32'h0000_0000);
    rdc(ATC_IDX_CNT_HI, 32'h0000_0000);
    rdc(ATC_IDX_IRQ_STAT, 32'h0000_0000);
    rdc(ATC_IDX_IRQ_MASK, 32'h0000_0000);
    rdc(10'h3ff, 32'h0000_0000);
    wr(10'h3ff, 32'h0000_00ff);
    $display("reset test done");
  endtask
  task automatic t_regs();
    wr(ATC_IDX_RLD_LO, 32'hffff_ffa5);
    wr(ATC_IDX_RLD_HI, 32'h0000_005a);
    wr(ATC_IDX_CNT_LO, 32'h0000_003c);
    wr(ATC_IDX_CNT_HI, 32'h0000_00c3);
    rdc(ATC_IDX_RLD_LO, 32'h0000_00a5);
    rdc(ATC_IDX_RLD_HI, 32'h0000_005a);
    rdc(ATC_IDX_CNT_LO, 32'h0000_003c);
    rdc(ATC_IDX_CNT_HI, 32'h0000_00c3);
    $display("register test done");
  endtask
  task automatic t_overflow();
    int n = 0;
    logic [31:0] a, b;
    wr(ATC_IDX_IRQ_MASK, 32'h0000_0001);
    wr(ATC_IDX_RLD_LO, 32'h0000_0000);
    wr(ATC_IDX_RLD_HI, 32'h0000_0012);
    wr(ATC_IDX_CNT_LO, 32'h0000_00fd);
    wr(ATC_IDX_CNT_HI, 32'h0000_00ff);
    wr(ATC_IDX_CTRL, 32'h0000_0004);
    while (irq !== 1'b1 && n < 30) begin
      @(posedge mclk);
      n++;
    end
    check({31'h0, irq}, 32'h0000_0001);
    rdc(ATC_IDX_CTRL, 32'h0000_0084);
    rdc(ATC_IDX_CNT_HI, 32'h0000_0012);
    rdc(ATC_IDX_IRQ_STAT, 32'h0000_0001);
    wr(ATC_IDX_IRQ_STAT, 32'h0000_0001);
    wr(ATC_IDX_CTRL, 32'h0000_0000);
    @(posedge mclk);
    check({31'h0, irq}, 32'h0000_0000);
    rdc(ATC_IDX_CTRL, 32'h0000_0000);
    bus(1'b0, ATC_IDX_CNT_LO, 32'h0000_0000, a);
    repeat (6) @(posedge mclk);
    bus(1'b0, ATC_IDX_CNT_LO, 32'h0000_0000, b);
    check(b, a);
    $display("overflow test done");
  endtask
  task automatic t_counter();
    wr(ATC_IDX_CNT_LO, 32'h0000_0000);
    wr(ATC_IDX_CTRL, 32'h0000_0006);
    repeat (3) i_atc_pin_model.pulse(1);
    rdc(ATC_IDX_CNT_LO, 32'h0000_0003);
    wr(ATC_IDX_CTRL, 32'h0000_0000);
    $display("counter test done");
  endtask
  task automatic t_trigger();
    wr(ATC_IDX_CNT_LO, 32'h0000_0055);
    wr(ATC_IDX_CTRL, 32'h0000_0001);
    i_atc_pin_model.pulse(0);
    rdc(ATC_IDX_RLD_LO, 32'h0000_0000);
    rdc(ATC_IDX_CTRL, 32'h0000_0001);
    wr(ATC_IDX_CTRL, 32'h0000_0009);
    i_atc_pin_model.pulse(0);
    rdc(ATC_IDX_RLD_LO, 32'h0000_0055);
    rdc(ATC_IDX_CTRL, 32'h0000_0049);
    check({31'h0, irq}, 32'h0000_0000);
    wr(ATC_IDX_IRQ_MASK, 32'h0000_0003);
    @(posedge mclk);
    check({31'h0, irq}, 32'h0000_0001);
    wr(ATC_IDX_IRQ_STAT, 32'h0000_0002);
    wr(ATC_IDX_RLD_LO, 32'h0000_0077);
    wr(ATC_IDX_CTRL, 32'h0000_0008);
    check({31'h0, irq}, 32'h0000_0000);
    i_atc_pin_model.pulse(0);
    rdc(ATC_IDX_CNT_LO, 32'h0000_0077);
    $display("trigger test done");
  endtask
  // Capture mode has no reload, so the count must wrap to zero on overflow
  task automatic t_wrap();
    wr(ATC_IDX_CNT_LO, 32'h0000_00ff);
    wr(ATC_IDX_CNT_HI, 32'h0000_00ff);
    wr(ATC_IDX_CTRL, 32'h0000_0005);
    repeat (6) @(posedge mclk);
    rdc(ATC_IDX_CTRL, 32'h0000_0085);
    wr(ATC_IDX_CTRL, 32'h0000_0000);
    rdc(ATC_IDX_CNT_HI, 32'h0000_0000);
    $display("wrap test done");
  endtask
  task automatic t_baud();
    wr(ATC_IDX_RLD_LO, 32'h0000_00ff);
    wr(ATC_IDX_RLD_HI, 32'h0000_00ff);
    // Start at all ones so the first tick overflows and every later one too
    wr(ATC_IDX_CNT_LO, 32'h0000_00ff);
    wr(ATC_IDX_CNT_HI, 32'h0000_00ff);
    for (int m = 0; m < 4; m++) begin
      i_atc_pin_model.set_mode(m[1:0]);
      r0 = i_atc_pin_model.rxTicks;
      t0 = i_atc_pin_model.txTicks;
      wr(ATC_IDX_CTRL, 32'h0000_0034);
      repeat (10) @(posedge mclk);
      wr(ATC_IDX_CTRL, 32'h0000_0030);
      rdc(ATC_IDX_CTRL, 32'h0000_0030);
      check(32'(i_atc_pin_model.rxTicks > r0), 32'(m[0]));
      check(32'(i_atc_pin_model.txTicks > t0), 32'(m[0]));
    end
    wr(ATC_IDX_CTRL, 32'h0000_0020);
    r0 = i_atc_pin_model.rxTicks;
    t0 = i_atc_pin_model.txTicks;
    i_atc_pin_model.other_pulse();
    check(32'(i_atc_pin_model.txTicks - t0), 32'h0000_0001);
    check(32'(i_atc_pin_model.rxTicks - r0), 32'h0000_0000);
    wr(ATC_IDX_CTRL, 32'h0000_0010);
    r0 = i_atc_pin_model.rxTicks;
    t0 = i_atc_pin_model.txTicks;
    i_atc_pin_model.other_pulse();
    check(32'(i_atc_pin_model.rxTicks - r0), 32'h0000_0001);
    check(32'(i_atc_pin_model.txTicks - t0), 32'h0000_0000);
    wr(ATC_IDX_CNT_LO, 32'h0000_0011);
    wr(ATC_IDX_CTRL, 32'h0000_0038);
    i_atc_pin_model.pulse(0);
    rdc(ATC_IDX_CTRL, 32'h0000_0038);
    rdc(ATC_IDX_CNT_LO, 32'h0000_0011);
    $display("baud test done");
  endtask
  // Reset in mid-run, with interrupt status, mask and bytes all nonzero beforehand
  task automatic t_reset_mid();
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0000_0000);
    check({30'h0, rxBaudTick, txBaudTick}, 32'h0000_0000);
    rst <= 1'b0;
    @(posedge mclk);
    rdc(ATC_IDX_CTRL, 32'h0000_0000);
    rdc(ATC_IDX_CNT_LO, 32'h0000_0000);
    rdc(ATC_IDX_RLD_HI, 32'h0000_0000);
    rdc(ATC_IDX_IRQ_MASK, 32'h0000_0000);
    $display("mid-run reset test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_regs();
    t_overflow();
    t_counter();
    t_trigger();
    t_wrap();
    t_baud();
    t_reset_mid();
    close_out();
  end
endmodule
